// ===== design/icp_pkg.sv
// icp_pkg: shared constants, states and carriers for the instruction cache port
// assumes: single clock domain, cache and core logic both on the system clock
package icp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths and sizes
    localparam int ADDR_W = 24;        // word address, bits 25 down to 2
    localparam int DATA_W = 32;
    localparam int LINE_WORDS = 4;     // one refill line, one lane enable per word
    localparam int LANE_W = 4;
    localparam int CNT_W = 3;          // counts 0..LINE_WORDS
    localparam int FIFO_DEPTH = 16;
    localparam int REGION_W = 4;       // top address bits select a cache region
    localparam int REGIONS = 16;
    localparam int REGION_LSB = ADDR_W - REGION_W;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
    localparam logic [LANE_W-1:0] LANE_NONE = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

    ////////////////////////////////////////////////////////////////////////////
    // state machines; refill is gray along the usual path, fetch flips both bits going FE_DATA to FE_IDLE
    typedef enum logic [1:0] {
        RF_IDLE = 2'h0,
        RF_MEM = 2'h1,
        RF_READY = 2'h3,
        RF_DRAIN = 2'h2
    } icp_refill_e;

    typedef enum logic [1:0] {
        FE_IDLE = 2'h0,
        FE_REQ = 2'h1,
        FE_DATA = 2'h3
    } icp_fetch_e;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic branch;
    } icp_fetch_s;

endpackage

// ===== design/icp_instruction_cache_port.sv
// icp_instruction_cache_port: core-side logic toward an attached instruction cache,
// with a refill path (cache miss -> external memory -> cache) and a fetch path.
// assumes: cache, memory port and pipeline run on clk; no synchronisers needed.

////////////////////////////////////////////////////////////////////////////////
// fifo with registered full/empty flags
module icp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_r;
    logic [PW-1:0] rdPtr_r;
    logic [PW:0] count_r;
    logic [PW:0] count_nxt;
    logic push;
    logic pop;

    // flags are flops so the top sees registered ready/valid
    assign push = inValid && inReady && ce;
    assign pop = outValid && outReady && ce;
    assign outData = mem[rdPtr_r];

    // occupancy after this cycle's push and pop
    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + (PW+1)'(1);
        end else if (pop && !push) begin
            count_nxt = count_r - (PW+1)'(1);
        end
    end

    // pointers, count and flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
            inReady <= 1'b1;
            outValid <= 1'b0;
        end else if (ce) begin
            if (push) begin
                wrPtr_r <= wrPtr_r + PW'(1);
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + PW'(1);
            end
            count_r <= count_nxt;
            inReady <= (count_nxt != DEPTH_CNT);
            outValid <= (count_nxt != '0);
        end
    end

    // storage; no reset needed, contents qualified by outValid
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// top: core end of the instruction cache port
module icp_instruction_cache_port #(
    parameter int LINE_WORDS = icp_pkg::LINE_WORDS,
    parameter int FIFO_DEPTH = icp_pkg::FIFO_DEPTH
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // refill path from the cache
    input wire logic cacheRefillRequest,
    input wire logic [icp_pkg::ADDR_W-1:0] cacheRefillAddress,
    input wire logic reservedTieLowInput,
    // refill path to the cache
    output logic refillAddressAck,
    output logic refillDataReady,
    output logic [icp_pkg::LANE_W-1:0] refillLaneLatchEnable,
    output logic [icp_pkg::DATA_W-1:0] refillDataOut,
    // external memory read port
    output logic memReadRequest,
    output logic [icp_pkg::ADDR_W-1:0] memReadAddress,
    input wire logic memReadAccept,
    input wire logic memDataValid,
    output logic memDataReady,
    input wire logic [icp_pkg::DATA_W-1:0] memData,
    // fetch path to the cache
    output logic cachedFetchRequest,
    output logic [icp_pkg::ADDR_W-1:0] cachedFetchAddress,
    output logic branchTargetFetchFlag,
    output logic fetchCancel,
    output logic uncachedStatusN,
    // fetch path from the cache
    input wire logic fetchAddressAck,
    input wire logic fetchDataLatchEnable,
    input wire logic [icp_pkg::DATA_W-1:0] fetchedInstructionData,
    // pipeline side
    input wire logic coreFetchValid,
    output logic coreFetchReady,
    input wire icp_pkg::icp_fetch_s coreFetch,
    input wire logic coreCancel,
    output logic coreDataValid,
    output logic [icp_pkg::DATA_W-1:0] coreData,
    // cache configuration, one cacheable bit per region
    input wire logic [icp_pkg::REGIONS-1:0] cacheConfigRegister
);
    icp_pkg::icp_refill_e refillState_r;
    icp_pkg::icp_fetch_e fetchState_r;
    logic [icp_pkg::CNT_W-1:0] wordsIn_r;
    logic [icp_pkg::CNT_W-1:0] wordsOut_r;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [icp_pkg::DATA_W-1:0] fifoOutData;
    logic memPush;
    logic fifoPop;
    logic takeFetch;
    logic cancelNow;
    localparam logic [icp_pkg::CNT_W-1:0] LINE_CNT = LINE_WORDS[icp_pkg::CNT_W-1:0];

    // region lookup: low output means the region is configured cacheable
    function automatic logic uncachedFor(input logic [icp_pkg::ADDR_W-1:0] a,
                                         input logic [icp_pkg::REGIONS-1:0] cfg);
        uncachedFor = !cfg[a[icp_pkg::ADDR_W-1:icp_pkg::REGION_LSB]];
    endfunction

    // word index to one-hot lane enable
    function automatic logic [icp_pkg::LANE_W-1:0] laneFor(input logic [icp_pkg::CNT_W-1:0] idx);
        laneFor = icp_pkg::LANE_NONE;
        laneFor[idx[1:0]] = 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // refill line buffer between external memory and cache
    assign memPush = memDataValid && memDataReady && ce;
    assign fifoOutReady = (refillState_r == icp_pkg::RF_DRAIN);
    assign fifoPop = fifoOutValid && fifoOutReady && ce;

    icp_fifo #(
        .WIDTH(icp_pkg::DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) icp_fifo_inst (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .inValid(memDataValid && (refillState_r == icp_pkg::RF_MEM)),
        .inReady(memDataReady),
        .inData(memData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // refill state machine: ack, memory read, data ready, lane drain
    // memDataValid is honoured only in RF_MEM; the word count guards the line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refillState_r <= icp_pkg::RF_IDLE;
            refillAddressAck <= 1'b0;
            memReadRequest <= 1'b0;
            memReadAddress <= icp_pkg::ADDR_RST;
            refillDataReady <= 1'b0;
            wordsIn_r <= icp_pkg::CNT_ZERO;
        end else if (ce) begin
            refillAddressAck <= 1'b0;
            refillDataReady <= 1'b0;
            case (refillState_r)
                icp_pkg::RF_IDLE: begin
                    if (cacheRefillRequest) begin
                        refillAddressAck <= 1'b1;
                        memReadRequest <= 1'b1;
                        memReadAddress <= cacheRefillAddress;
                        wordsIn_r <= icp_pkg::CNT_ZERO;
                        refillState_r <= icp_pkg::RF_MEM;
                    end
                end
                icp_pkg::RF_MEM: begin
                    if (memReadAccept) begin
                        memReadRequest <= 1'b0;
                    end
                    if (memPush && refillState_r == icp_pkg::RF_MEM) begin
                        wordsIn_r <= wordsIn_r + icp_pkg::CNT_ONE;
                        if (wordsIn_r + icp_pkg::CNT_ONE == LINE_CNT) begin
                            refillState_r <= icp_pkg::RF_READY;
                        end
                    end
                end
                icp_pkg::RF_READY: begin
                    // ack was given in an earlier cycle, so ready always trails it
                    refillDataReady <= 1'b1;
                    refillState_r <= icp_pkg::RF_DRAIN;
                end
                icp_pkg::RF_DRAIN: begin
                    if (fifoPop && wordsOut_r + icp_pkg::CNT_ONE == LINE_CNT) begin
                        refillState_r <= icp_pkg::RF_IDLE;
                    end
                end
                default: begin
                    refillState_r <= icp_pkg::RF_IDLE;
                end
            endcase
        end
    end

    // lane drain: one word per cycle, lane enable marks where it lands
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wordsOut_r <= icp_pkg::CNT_ZERO;
            refillLaneLatchEnable <= icp_pkg::LANE_NONE;
            refillDataOut <= icp_pkg::DATA_RST;
        end else if (ce) begin
            refillLaneLatchEnable <= icp_pkg::LANE_NONE;
            if (refillState_r == icp_pkg::RF_READY) begin
                wordsOut_r <= icp_pkg::CNT_ZERO;
            end else if (fifoPop) begin
                refillLaneLatchEnable <= laneFor(wordsOut_r);
                refillDataOut <= fifoOutData;
                wordsOut_r <= wordsOut_r + icp_pkg::CNT_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fetch path
    assign takeFetch = coreFetchValid && coreFetchReady;
    assign cancelNow = coreCancel && (fetchState_r != icp_pkg::FE_IDLE);

    // fetch state machine; cancel beats a same-cycle ack or data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetchState_r <= icp_pkg::FE_IDLE;
            coreFetchReady <= 1'b1;
            cachedFetchRequest <= 1'b0;
            cachedFetchAddress <= icp_pkg::ADDR_RST;
            branchTargetFetchFlag <= 1'b0;
            uncachedStatusN <= 1'b1;
            fetchCancel <= 1'b0;
        end else if (ce) begin
            fetchCancel <= 1'b0;
            case (fetchState_r)
                icp_pkg::FE_IDLE: begin
                    if (takeFetch) begin
                        cachedFetchRequest <= 1'b1;
                        cachedFetchAddress <= coreFetch.addr;
                        branchTargetFetchFlag <= coreFetch.branch;
                        uncachedStatusN <= uncachedFor(coreFetch.addr, cacheConfigRegister);
                        coreFetchReady <= 1'b0;
                        fetchState_r <= icp_pkg::FE_REQ;
                    end
                end
                icp_pkg::FE_REQ: begin
                    // request and address left untouched until ack or cancel
                    if (cancelNow) begin
                        fetchCancel <= 1'b1;
                        cachedFetchRequest <= 1'b0;
                        branchTargetFetchFlag <= 1'b0;
                        coreFetchReady <= 1'b1;
                        fetchState_r <= icp_pkg::FE_IDLE;
                    end else if (fetchAddressAck) begin
                        cachedFetchRequest <= 1'b0;
                        fetchState_r <= icp_pkg::FE_DATA;
                    end
                end
                icp_pkg::FE_DATA: begin
                    if (cancelNow) begin
                        fetchCancel <= 1'b1;
                    end
                    if (cancelNow || fetchDataLatchEnable) begin
                        branchTargetFetchFlag <= 1'b0;
                        coreFetchReady <= 1'b1;
                        fetchState_r <= icp_pkg::FE_IDLE;
                    end
                end
                default: begin
                    fetchState_r <= icp_pkg::FE_IDLE;
                end
            endcase
        end
    end

    // instruction word capture toward the pipeline; dropped when cancelled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coreDataValid <= 1'b0;
            coreData <= icp_pkg::DATA_RST;
        end else if (ce) begin
            coreDataValid <= 1'b0;
            if (fetchState_r == icp_pkg::FE_DATA && fetchDataLatchEnable && !coreCancel) begin
                coreDataValid <= 1'b1;
                coreData <= fetchedInstructionData;
            end
        end
    end

    // reservedTieLowInput is tied low by the system and deliberately unused
endmodule

// ===== tb/icp_instruction_cache_port_assertions.sv
// icp_instruction_cache_port_assertions: port-level checks of the cache port
// assumes: bound to the top module, one clock, ce held high
module icp_instruction_cache_port_assertions #(
    parameter int LINE_WORDS = 4,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // refill path
    input wire logic cacheRefillRequest,
    input wire logic refillAddressAck,
    input wire logic refillDataReady,
    input wire logic [icp_pkg::LANE_W-1:0] refillLaneLatchEnable,
    // fetch path
    input wire logic coreFetchValid,
    input wire logic coreFetchReady,
    input wire icp_pkg::icp_fetch_s coreFetch,
    input wire logic coreCancel,
    input wire logic cachedFetchRequest,
    input wire logic [icp_pkg::ADDR_W-1:0] cachedFetchAddress,
    input wire logic branchTargetFetchFlag,
    input wire logic fetchCancel,
    input wire logic fetchAddressAck,
    input wire logic fetchDataLatchEnable,
    input wire logic [icp_pkg::DATA_W-1:0] fetchedInstructionData,
    input wire logic coreDataValid,
    input wire logic [icp_pkg::DATA_W-1:0] coreData
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic ackSeen_r;
    ////////////////////////////////////////////////////////////
    // remembers the address ack until data ready, so ready cannot overtake it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ackSeen_r <= 1'b0;
        end else if (refillAddressAck || refillDataReady) begin
            ackSeen_r <= refillAddressAck;
        end
    end
    // refill handshake
    property p_ackPulse; refillAddressAck |-> $past(cacheRefillRequest) ##1 !refillAddressAck; endproperty
    a_ackPulse: assert property (p_ackPulse) else $error("refill ack without request");
    property p_readyOrder; refillDataReady |-> ackSeen_r; endproperty
    a_readyOrder: assert property (p_readyOrder) else $error("data ready before ack");
    property p_lanes; refillDataReady |=> refillLaneLatchEnable == 4'h1 ##1 refillLaneLatchEnable == 4'h2
        ##1 refillLaneLatchEnable == 4'h4 ##1 refillLaneLatchEnable == 4'h8; endproperty
    a_lanes: assert property (p_lanes) else $error("lane enables out of order");
    // fetch handshake
    property p_fetchIssue; coreFetchValid && coreFetchReady |=> cachedFetchRequest
        && cachedFetchAddress == $past(coreFetch.addr) && branchTargetFetchFlag == $past(coreFetch.branch); endproperty
    a_fetchIssue: assert property (p_fetchIssue) else $error("fetch not issued");
    property p_fetchHold; cachedFetchRequest && !fetchAddressAck && !coreCancel
        |=> cachedFetchRequest && $stable(cachedFetchAddress); endproperty
    a_fetchHold: assert property (p_fetchHold) else $error("fetch request not held");
    property p_reqDrop; cachedFetchRequest && fetchAddressAck |=> !cachedFetchRequest; endproperty
    a_reqDrop: assert property (p_reqDrop) else $error("request kept after ack");
    property p_cancel; cachedFetchRequest && coreCancel |=> fetchCancel && !cachedFetchRequest; endproperty
    a_cancel: assert property (p_cancel) else $error("cancel not issued");
    property p_dataOut; coreDataValid |-> $past(fetchDataLatchEnable)
        && coreData == $past(fetchedInstructionData); endproperty
    a_dataOut: assert property (p_dataOut) else $error("fetched word not passed on");
endmodule
bind icp_instruction_cache_port icp_instruction_cache_port_assertions #(.LINE_WORDS(LINE_WORDS),
    .FIFO_DEPTH(FIFO_DEPTH)) icp_instruction_cache_port_assertions_inst (.*);

// ===== tb/icp_cache_model.sv
// icp_cache_model: behavioural instruction cache on the far side of the port
// assumes: the bench starts misses with missGo and picks the ack delay
module icp_cache_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench control
    input wire logic missGo,
    input wire logic [icp_pkg::ADDR_W-1:0] missAddr,
    input wire logic [3:0] ackDelay,
    // refill side
    output logic cacheRefillRequest,
    output logic [icp_pkg::ADDR_W-1:0] cacheRefillAddress,
    input wire logic refillAddressAck,
    // fetch side
    input wire logic cachedFetchRequest,
    input wire logic [icp_pkg::ADDR_W-1:0] cachedFetchAddress,
    output logic fetchAddressAck,
    output logic fetchDataLatchEnable,
    output logic [icp_pkg::DATA_W-1:0] fetchedInstructionData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCnt_r;
    logic [icp_pkg::DATA_W-1:0] word_r;
    ////////////////////////////////////////////////////////////
    // miss held until acked; address garbled while idle so a stale value cannot pass
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cacheRefillRequest <= 1'b0;
            cacheRefillAddress <= 24'hFFFFFF;
        end else if (missGo) begin
            cacheRefillRequest <= 1'b1;
            cacheRefillAddress <= missAddr;
        end else if (refillAddressAck) begin
            cacheRefillRequest <= 1'b0;
            cacheRefillAddress <= ~cacheRefillAddress;
        end
    end
    // ack after ackDelay cycles, then one latch enable; data garbled outside it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitCnt_r <= 4'h0;
            fetchAddressAck <= 1'b0;
            fetchDataLatchEnable <= 1'b0;
            fetchedInstructionData <= 32'h00000000;
            word_r <= 32'h00000000;
        end else begin
            fetchAddressAck <= 1'b0;
            fetchDataLatchEnable <= fetchAddressAck;
            fetchedInstructionData <= fetchAddressAck ? word_r : ~fetchedInstructionData;
            if (!cachedFetchRequest || fetchAddressAck) begin
                waitCnt_r <= 4'h0;
            end else if (waitCnt_r == ackDelay) begin
                fetchAddressAck <= 1'b1;
                word_r <= {cachedFetchAddress, 8'h5A};
            end else begin
                waitCnt_r <= waitCnt_r + 4'h1;
            end
        end
    end
endmodule

// ===== tb/icp_instruction_cache_port_tb.sv
// icp_instruction_cache_port_tb: self-checking bench for the instruction cache port
// assumes: cache model on the cache pins; the bench plays pipeline and memory
module icp_instruction_cache_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic reservedTieLowInput = 1'b0;
    logic memReadAccept = 1'b0, memDataValid = 1'b0, coreFetchValid = 1'b0, coreCancel = 1'b0, missGo = 1'b0;
    logic [31:0] memData = 32'h00000000;
    logic [23:0] missAddr = 24'h000000;
    logic [3:0] ackDelay = 4'h0;
    logic [15:0] cacheConfigRegister = 16'hA5C3;
    icp_pkg::icp_fetch_s coreFetch = '0;
    logic cacheRefillRequest, refillAddressAck, refillDataReady, memReadRequest, memDataReady;
    logic cachedFetchRequest, branchTargetFetchFlag, fetchCancel, uncachedStatusN, fetchAddressAck;
    logic fetchDataLatchEnable, coreFetchReady, coreDataValid;
    logic [3:0] refillLaneLatchEnable;
    logic [23:0] cacheRefillAddress, memReadAddress, cachedFetchAddress;
    logic [31:0] refillDataOut, fetchedInstructionData, coreData;
    logic [3:0] ev;
    int nMismatch = 0;
    int checked = 0;
    icp_instruction_cache_port icp_instruction_cache_port_inst (.*);
    icp_cache_model icp_cache_model_inst (.*);
    always #20 clk = ~clk;
    assign ev = {coreDataValid, refillDataReady, refillAddressAck, coreFetchReady};
    ////////////////////////////////////////////////////////////
    // shared helpers
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // polls one event bit after each edge; a hang counts as a mismatch
    task automatic waitFor(input int i);
        int n = 0;
        while (ev[i] !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 40) begin
                check(32'h0, 32'h1);
                end_of_test();
            end
        end
    endtask
    function automatic logic [31:0] word(input logic [23:0] a, input int k);
        return {8'h50 + 8'(k), a};
    endfunction
    ////////////////////////////////////////////////////////////
    // miss through memory with a stall mid-line, then the line lane by lane
    task automatic t_refill(input logic [23:0] a);
        int k = 0;
        missAddr = a;
        missGo = 1'b1;
        @(posedge clk);
        #1;
        missGo = 1'b0;
        waitFor(1);
        check(memReadAddress, a);
        check({memReadRequest, memDataReady}, 2'b11);
        memReadAccept = 1'b1;
        for (int n = 0; k < 4 && n < 20; n++) begin
            @(posedge clk);
            if (memDataValid && memDataReady) k++;
            #1;
            memReadAccept = 1'b0;
            memDataValid = k < 4 && n != 2;
            memData = memDataValid ? word(a, k) : ~memData;
        end
        check(memReadRequest, 1'b0);
        waitFor(2);
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            #1;
            check(refillLaneLatchEnable, 1 << k);
            check(refillDataOut, word(a, k));
        end
    endtask
    // one fetch, taken as soon as the port is ready, so fetches run back to back
    task automatic t_fetch(input logic [23:0] a, input logic br, input logic [3:0] d);
        ackDelay = d;
        waitFor(0);
        coreFetch = {a, br};
        coreFetchValid = 1'b1;
        @(posedge clk);
        #1;
        coreFetchValid = 1'b0;
        check(cachedFetchRequest, 1'b1);
        check(cachedFetchAddress, a);
        check(coreFetchReady, 1'b0);
        check(branchTargetFetchFlag, br);
        check(uncachedStatusN, !cacheConfigRegister[a[23:20]]);
        waitFor(3);
        check(coreData, {a, 8'h5A});
    endtask
    // cancel while idle is ignored; cancel while waiting for ack withdraws the fetch
    task automatic t_cancel();
        logic late = 1'b0;
        coreCancel = 1'b1;
        @(posedge clk);
        #1;
        coreCancel = 1'b0;
        check(fetchCancel, 1'b0);
        t_fetch_start(24'h123456, 4'h6);
        coreCancel = 1'b1;
        @(posedge clk);
        #1;
        coreCancel = 1'b0;
        check({fetchCancel, cachedFetchRequest}, 2'b10);
        repeat (10) begin
            @(posedge clk);
            #1;
            late = late | coreDataValid;
        end
        check(late, 1'b0);
        // cancel landing on the latch enable cycle: word dropped, cancel still pulsed
        t_fetch_start(24'h0ABCD0, 4'h0);
        repeat (2) @(posedge clk);
        #1;
        coreCancel = 1'b1;
        @(posedge clk);
        #1;
        coreCancel = 1'b0;
        check({fetchCancel, coreDataValid, coreFetchReady}, 3'b101);
    endtask
    task automatic t_fetch_start(input logic [23:0] a, input logic [3:0] d);
        ackDelay = d;
        waitFor(0);
        coreFetch = {a, 1'b1};
        coreFetchValid = 1'b1;
        @(posedge clk);
        #1;
        coreFetchValid = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        check({coreFetchReady, uncachedStatusN}, 2'b11);
        t_refill(24'h000000);
        t_refill(24'hFFFFFF);
        t_fetch(24'h012340, 1'b0, 4'h0);
        t_fetch(24'h2ABCDE, 1'b1, 4'h0);
        t_fetch(24'hFFFFFF, 1'b1, 4'h3);
        t_cancel();
        t_fetch(24'h000004, 1'b0, 4'h1);
        end_of_test();
    end
endmodule
